/* File: logic/irq_pkg.sv */
// constants, register map and event carriers of the usb interrupt arbiter
package irq_pkg;
  // timing
  localparam int unsigned CLK_HZ      = 125_000_000;
  localparam int unsigned TICK_HZ     = 750_000;              // 12 MHz / 16
  localparam int unsigned TICK_CYCLES = CLK_HZ / TICK_HZ;     // rounds down
  localparam int unsigned FRAME_US    = 1000;
  localparam int unsigned FRAME_TICKS = TICK_HZ / 1000 * FRAME_US / 1000;

  // source vector layout, index 0 has the highest priority
  localparam int unsigned NSRC         = 51;
  localparam int unsigned BUS_RESET    = 0;
  localparam int unsigned BUS_SETUP    = 3;
  localparam int unsigned BUS_SETUP_OW = 4;
  localparam int unsigned PRE_FRAME    = 6;
  localparam int unsigned OUT_EP_BASE  = 7;
  localparam int unsigned IN_EP_BASE   = 15;
  localparam int unsigned OUT_RUN_BASE = 23;
  localparam int unsigned OUT_RLD_BASE = 30;
  localparam int unsigned IN_RUN_BASE  = 37;
  localparam int unsigned IN_RLD_BASE  = 44;
  localparam logic [5:0]  CODE_SETUP    = 6'h04;
  localparam logic [5:0]  CODE_SETUP_OW = 6'h05;

  // register byte offsets
  localparam int unsigned ADDR_W = 8;
  localparam logic [7:0] OFF_BUS_FLAG  = 8'h00;
  localparam logic [7:0] OFF_BUS_EN    = 8'h04;
  localparam logic [7:0] OFF_OUT_FLAG  = 8'h08;
  localparam logic [7:0] OFF_OUT_EN    = 8'h0c;
  localparam logic [7:0] OFF_IN_FLAG   = 8'h10;
  localparam logic [7:0] OFF_IN_EN     = 8'h14;
  localparam logic [7:0] OFF_OUT0_CFG  = 8'h18;
  localparam logic [7:0] OFF_IN0_CFG   = 8'h1c;
  localparam logic [7:0] OFF_ODRUN     = 8'h20;
  localparam logic [7:0] OFF_ODRLD     = 8'h24;
  localparam logic [7:0] OFF_ODEN      = 8'h28;
  localparam logic [7:0] OFF_IDRUN     = 8'h2c;
  localparam logic [7:0] OFF_IDRLD     = 8'h30;
  localparam logic [7:0] OFF_IDEN      = 8'h34;
  localparam logic [7:0] OFF_SRC_CODE  = 8'h38;
  localparam logic [7:0] OFF_PF_COUNT  = 8'h3c;
  localparam logic [7:0] OFF_IDLE_CTRL = 8'h40;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one-cycle event pulses from the usb core, dma bit i is endpoint i+1
  typedef struct packed {
    logic sof;
    logic setup;
    logic resume;
    logic suspend;
    logic reset;
  } bus_evt_s;
  typedef struct packed {
    logic [7:0] in_done;
    logic [7:0] out_done;
  } ep_evt_s;
  typedef struct packed {
    logic [6:0] in_reload;
    logic [6:0] in_run;
    logic [6:0] out_reload;
    logic [6:0] out_run;
  } dma_evt_s;
endpackage : irq_pkg

/* File: logic/usb_interrupt_arbiter.sv */
// usb interrupt flags, enables, fixed-priority arbiter and axi4-lite registers
// Behaviour
// - all bus, endpoint and dma requests merge onto one interrupt line.
// - simultaneous requests are served one at a time by fixed priority.
// - reading the source code clears the flag of the returned request.
// - setup and setup-overwrite flags clear only by writing one.
// - after that read the next highest pending request is coded and raised.
// - bus events set flags; only enabled flags forward a request.
// - reset, suspend, resume, setup and frame start each have a flag.
// - pre-frame flag fires n 750 kHz ticks before each frame start.
// - endpoints one to seven request when flag and enable are set.
// - endpoint zero also needs its local configuration enable bit.
// - a received out packet sets the endpoint nak bit and flag.
// - a sent in packet sets the endpoint nak bit and flag.
// - dma run or reload clearing on endpoints one to seven sets flags.
// - each endpoint direction has run and reload flags, one shared enable.
// - dma request passes when either flag and the enable are set.
// - with idle permit set the module idles with the peripheral domain.
`timescale 1ns/1ps
module usb_interrupt_arbiter (
  // clock and reset
  input  wire logic                        aclk,
  input  wire logic                        aresetn,
  // axi4-lite write
  input  wire logic [irq_pkg::ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]                  awprot,
  input  wire logic                        awvalid,
  output logic                             awready,
  input  wire logic [31:0]                 wdata,
  input  wire logic [3:0]                  wstrb,
  input  wire logic                        wvalid,
  output logic                             wready,
  output logic [1:0]                       bresp,
  output logic                             bvalid,
  input  wire logic                        bready,
  // axi4-lite read
  input  wire logic [irq_pkg::ADDR_W-1:0]  araddr,
  input  wire logic [2:0]                  arprot,
  input  wire logic                        arvalid,
  output logic                             arready,
  output logic [31:0]                      rdata,
  output logic [1:0]                       rresp,
  output logic                             rvalid,
  input  wire logic                        rready,
  // event pulses from usb core, buffer manager and dma controller
  input  wire irq_pkg::bus_evt_s           bus_evt,
  input  wire logic                        setup_buf_read,
  input  wire irq_pkg::ep_evt_s            ep_evt,
  input  wire irq_pkg::dma_evt_s           dma_evt,
  // endpoint nak set pulses to the count registers
  output logic [7:0]                       out_ep_nak_set,
  output logic [7:0]                       in_ep_nak_set,
  // cpu request line and idle handshake
  output logic                             usb_irq,
  input  wire logic                        periph_domain_idle_bit,
  output logic                             module_idle
);

  localparam int unsigned N = irq_pkg::NSRC;

  logic [N-1:0] flag_reg, flag_next, set_vec, wr_clr, rd_clr, en_vec, pending;
  logic [6:0]   bus_event_enable_reg, out_dma_enable_reg, in_dma_enable_reg;
  logic [7:0]   out_ep_enable_reg, in_ep_enable_reg, pre_frame_countdown_reg;
  logic         out_ep_zero_config_reg, in_ep_zero_config_reg, module_idle_permit_reg;
  logic [5:0]   interrupt_source_code_reg;
  logic         irq_reg, idle_reg, setup_pend_reg, ow_hit, pf_hit, tick;
  logic         wr_fire, ar_fire, rd_src, bvalid_reg, rvalid_reg;
  logic [1:0]   bresp_reg, rresp_reg;
  logic [31:0]  rdata_reg;
  logic [7:0]   rd_byte, out_nak_reg, in_nak_reg;
  logic [7:0]   tick_cnt_reg;
  logic [9:0]   frame_cnt_reg;
  logic         idle_sync1_reg, idle_sync2_reg;

  // word decode shared by both channels
  function automatic logic addr_ok(input logic [irq_pkg::ADDR_W-1:0] a);
    return (a[1:0] == 2'h0) && (a <= irq_pkg::OFF_IDLE_CTRL);
  endfunction : addr_ok

  // lowest set index wins, code is index plus one, zero when idle
  function automatic logic [5:0] prio_code(input logic [N-1:0] p);
    logic [5:0] c;
    c = 6'h00;
    for (int i = N - 1; i >= 0; i--) begin
      if (p[i]) begin
        c = 6'(i + 1);
      end
    end
    return c;
  endfunction : prio_code

  // write-one-to-clear map of the flag registers
  function automatic logic [N-1:0] w1c_map(input logic [irq_pkg::ADDR_W-1:0] a,
                                           input logic [7:0] d);
    logic [N-1:0] m;
    m = '0;
    case (a)
      irq_pkg::OFF_BUS_FLAG: m[6:0] = d[6:0];
      irq_pkg::OFF_OUT_FLAG: m[irq_pkg::OUT_EP_BASE +: 8] = d;
      irq_pkg::OFF_IN_FLAG:  m[irq_pkg::IN_EP_BASE +: 8] = d;
      irq_pkg::OFF_ODRUN:    m[irq_pkg::OUT_RUN_BASE +: 7] = d[7:1];
      irq_pkg::OFF_ODRLD:    m[irq_pkg::OUT_RLD_BASE +: 7] = d[7:1];
      irq_pkg::OFF_IDRUN:    m[irq_pkg::IN_RUN_BASE +: 7] = d[7:1];
      irq_pkg::OFF_IDRLD:    m[irq_pkg::IN_RLD_BASE +: 7] = d[7:1];
      default:               m = '0;
    endcase
    return m;
  endfunction : w1c_map

  // axi handshakes: write address and data are taken together
  assign wr_fire = awvalid && wvalid && !bvalid_reg;
  assign awready = wr_fire;
  assign wready  = wr_fire;
  assign arready = !rvalid_reg;
  assign ar_fire = arvalid && !rvalid_reg;
  assign rd_src  = ar_fire && (araddr == irq_pkg::OFF_SRC_CODE);
  assign bvalid  = bvalid_reg;
  assign bresp   = bresp_reg;
  assign rvalid  = rvalid_reg;
  assign rresp   = rresp_reg;
  assign rdata   = rdata_reg;

  // event sources in priority order
  assign ow_hit  = bus_evt.setup && setup_pend_reg;
  assign set_vec = {dma_evt.in_reload, dma_evt.in_run,
                    dma_evt.out_reload, dma_evt.out_run,
                    ep_evt.in_done, ep_evt.out_done,
                    pf_hit, bus_evt.sof, ow_hit, bus_evt.setup,
                    bus_evt.resume, bus_evt.suspend, bus_evt.reset};

  // gating: dma enable is shared by run and reload flags
  assign en_vec = {in_dma_enable_reg, in_dma_enable_reg,
                   out_dma_enable_reg, out_dma_enable_reg,
                   in_ep_enable_reg & {7'h7f, in_ep_zero_config_reg},
                   out_ep_enable_reg & {7'h7f, out_ep_zero_config_reg},
                   bus_event_enable_reg};
  assign pending = flag_reg & en_vec;

  // read of the source code clears the served flag, setup pair excluded
  always_comb begin
    rd_clr = '0;
    if (rd_src && interrupt_source_code_reg != 6'h00 &&
        interrupt_source_code_reg != irq_pkg::CODE_SETUP &&
        interrupt_source_code_reg != irq_pkg::CODE_SETUP_OW) begin
      rd_clr[interrupt_source_code_reg - 6'h01] = 1'b1;
    end
  end

  // set wins over any clear in the same cycle
  always_comb begin
    wr_clr    = (wr_fire && wstrb[0]) ? w1c_map(awaddr, wdata[7:0]) : '0;
    flag_next = (flag_reg & ~(wr_clr | rd_clr)) | set_vec;
  end

  // sticky flags
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flag_reg <= '0;
    end else begin
      flag_reg <= flag_next;
    end
  end

  // arbiter output, recomputed every edge so a read reselects at once
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      interrupt_source_code_reg <= 6'h00;
      irq_reg                   <= 1'b0;
    end else begin
      interrupt_source_code_reg <= prio_code(flag_next & en_vec);
      irq_reg                   <= |(flag_next & en_vec);
    end
  end
  assign usb_irq = irq_reg;

  // setup buffer occupancy, new arrival wins over a read in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      setup_pend_reg <= 1'b0;
    end else if (bus_evt.setup) begin
      setup_pend_reg <= 1'b1;
    end else if (setup_buf_read) begin
      setup_pend_reg <= 1'b0;
    end
  end

  // 750 kHz tick; realigned on every frame start
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_evt.sof || tick) begin
      tick_cnt_reg <= 8'h00;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 8'h01;
    end
  end
  assign tick = (tick_cnt_reg == 8'(irq_pkg::TICK_CYCLES - 1));

  // ticks since the last frame start, saturating if frames stop
  always_ff @(posedge aclk) begin
    if (!aresetn || bus_evt.sof) begin
      frame_cnt_reg <= 10'h000;
    end else if (tick && frame_cnt_reg != 10'h3ff) begin
      frame_cnt_reg <= frame_cnt_reg + 10'h001;
    end
  end
  // zero countdown disables the pre-frame event
  assign pf_hit = tick && (pre_frame_countdown_reg != 8'h00) &&
                  (frame_cnt_reg + 10'h001 ==
                   10'(irq_pkg::FRAME_TICKS) - {2'h0, pre_frame_countdown_reg});

  // nak set pulses follow the packet event by one edge
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_nak_reg <= 8'h00;
      in_nak_reg  <= 8'h00;
    end else begin
      out_nak_reg <= ep_evt.out_done;
      in_nak_reg  <= ep_evt.in_done;
    end
  end
  assign out_ep_nak_set = out_nak_reg;
  assign in_ep_nak_set  = in_nak_reg;

  // idle level comes from another domain, so two flops first
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      idle_sync1_reg <= 1'b0;
      idle_sync2_reg <= 1'b0;
      idle_reg       <= 1'b0;
    end else begin
      idle_sync1_reg <= periph_domain_idle_bit;
      idle_sync2_reg <= idle_sync1_reg;
      idle_reg       <= module_idle_permit_reg && idle_sync2_reg;
    end
  end
  assign module_idle = idle_reg;

  // software-owned enables and configuration
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_event_enable_reg    <= 7'h00;
      out_ep_enable_reg       <= 8'h00;
      in_ep_enable_reg        <= 8'h00;
      out_ep_zero_config_reg  <= 1'b0;
      in_ep_zero_config_reg   <= 1'b0;
      out_dma_enable_reg      <= 7'h00;
      in_dma_enable_reg       <= 7'h00;
      pre_frame_countdown_reg <= 8'h00;
      module_idle_permit_reg  <= 1'b0;
    end else if (wr_fire && wstrb[0]) begin
      case (awaddr)
        irq_pkg::OFF_BUS_EN:    bus_event_enable_reg    <= wdata[6:0];
        irq_pkg::OFF_OUT_EN:    out_ep_enable_reg       <= wdata[7:0];
        irq_pkg::OFF_IN_EN:     in_ep_enable_reg        <= wdata[7:0];
        irq_pkg::OFF_OUT0_CFG:  out_ep_zero_config_reg  <= wdata[0];
        irq_pkg::OFF_IN0_CFG:   in_ep_zero_config_reg   <= wdata[0];
        irq_pkg::OFF_ODEN:      out_dma_enable_reg      <= wdata[7:1];
        irq_pkg::OFF_IDEN:      in_dma_enable_reg       <= wdata[7:1];
        irq_pkg::OFF_PF_COUNT:  pre_frame_countdown_reg <= wdata[7:0];
        irq_pkg::OFF_IDLE_CTRL: module_idle_permit_reg  <= wdata[0];
        default: ;
      endcase
    end
  end

  // write response; unmapped words answer slverr
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= irq_pkg::RESP_OKAY;
    end else if (wr_fire) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= addr_ok(awaddr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
    end else if (bready) begin
      bvalid_reg <= 1'b0;
    end
  end

  // read mux; dma registers use bits 7:1 for endpoints one to seven
  always_comb begin
    case (araddr)
      irq_pkg::OFF_BUS_FLAG:  rd_byte = {1'b0, flag_reg[6:0]};
      irq_pkg::OFF_BUS_EN:    rd_byte = {1'b0, bus_event_enable_reg};
      irq_pkg::OFF_OUT_FLAG:  rd_byte = flag_reg[irq_pkg::OUT_EP_BASE +: 8];
      irq_pkg::OFF_OUT_EN:    rd_byte = out_ep_enable_reg;
      irq_pkg::OFF_IN_FLAG:   rd_byte = flag_reg[irq_pkg::IN_EP_BASE +: 8];
      irq_pkg::OFF_IN_EN:     rd_byte = in_ep_enable_reg;
      irq_pkg::OFF_OUT0_CFG:  rd_byte = {7'h00, out_ep_zero_config_reg};
      irq_pkg::OFF_IN0_CFG:   rd_byte = {7'h00, in_ep_zero_config_reg};
      irq_pkg::OFF_ODRUN:     rd_byte = {flag_reg[irq_pkg::OUT_RUN_BASE +: 7], 1'b0};
      irq_pkg::OFF_ODRLD:     rd_byte = {flag_reg[irq_pkg::OUT_RLD_BASE +: 7], 1'b0};
      irq_pkg::OFF_ODEN:      rd_byte = {out_dma_enable_reg, 1'b0};
      irq_pkg::OFF_IDRUN:     rd_byte = {flag_reg[irq_pkg::IN_RUN_BASE +: 7], 1'b0};
      irq_pkg::OFF_IDRLD:     rd_byte = {flag_reg[irq_pkg::IN_RLD_BASE +: 7], 1'b0};
      irq_pkg::OFF_IDEN:      rd_byte = {in_dma_enable_reg, 1'b0};
      irq_pkg::OFF_SRC_CODE:  rd_byte = {2'h0, interrupt_source_code_reg};
      irq_pkg::OFF_PF_COUNT:  rd_byte = pre_frame_countdown_reg;
      irq_pkg::OFF_IDLE_CTRL: rd_byte = {6'h00, idle_reg, module_idle_permit_reg};
      default:                rd_byte = 8'h00;
    endcase
  end

  // read data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid_reg <= 1'b0;
      rresp_reg  <= irq_pkg::RESP_OKAY;
      rdata_reg  <= 32'h0000_0000;
    end else if (ar_fire) begin
      rvalid_reg <= 1'b1;
      rresp_reg  <= addr_ok(araddr) ? irq_pkg::RESP_OKAY : irq_pkg::RESP_SLVERR;
      rdata_reg  <= {24'h00_0000, rd_byte};
    end else if (rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_quiet;
    ($past(flag_next & en_vec) == '0) |-> (!usb_irq && interrupt_source_code_reg == 6'h00);
  endproperty
  a_quiet: assert property (p_quiet) else $error("line or code active with nothing pending");

  property p_top_prio;
    $past(flag_next[0] && en_vec[0]) |-> (usb_irq && interrupt_source_code_reg == 6'h01);
  endproperty
  a_top_prio: assert property (p_top_prio) else $error("bus reset not coded first");

  property p_read_clear;
    (|$past(rd_clr)) |-> ((flag_reg & $past(rd_clr) & ~$past(set_vec)) == '0);
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("served flag not cleared");

  property p_setup_keep;
    (rd_src && interrupt_source_code_reg == irq_pkg::CODE_SETUP && !wr_clr[3])
      |=> flag_reg[irq_pkg::BUS_SETUP];
  endproperty
  a_setup_keep: assert property (p_setup_keep) else $error("setup flag cleared by read");

  property p_reselect;
    (|rd_clr) ##1 ((|pending) && !wr_fire && !rd_src) |=>
      (usb_irq && interrupt_source_code_reg != 6'h00);
  endproperty
  a_reselect: assert property (p_reselect) else $error("next request not raised");

  property p_bus_fwd;
    (bus_evt.reset && bus_event_enable_reg[0]) ##1 (!wr_fire && !rd_src) |=> usb_irq;
  endproperty
  a_bus_fwd: assert property (p_bus_fwd) else $error("enabled bus reset not raised");

  property p_overwrite;
    (bus_evt.setup && setup_pend_reg) |=> flag_reg[irq_pkg::BUS_SETUP_OW];
  endproperty
  a_overwrite: assert property (p_overwrite) else $error("setup overwrite missed");

  property p_pre_frame;
    $rose(flag_reg[irq_pkg::PRE_FRAME]) |->
      ($past(frame_cnt_reg) + 10'h001 + {2'h0, $past(pre_frame_countdown_reg)}
       == 10'(irq_pkg::FRAME_TICKS));
  endproperty
  a_pre_frame: assert property (p_pre_frame) else $error("pre-frame at wrong tick");

  property p_nak;
    ep_evt.out_done[1] |=> (out_ep_nak_set[1] && flag_reg[irq_pkg::OUT_EP_BASE + 1]);
  endproperty
  a_nak: assert property (p_nak) else $error("nak or flag missing");

  // checked at the coded output, so a broken gate or encoder both show
  property p_ep0_gate;
    (!out_ep_zero_config_reg || !in_ep_zero_config_reg) |=>
      (($past(out_ep_zero_config_reg) ||
        interrupt_source_code_reg != 6'(irq_pkg::OUT_EP_BASE + 1)) &&
       ($past(in_ep_zero_config_reg) ||
        interrupt_source_code_reg != 6'(irq_pkg::IN_EP_BASE + 1)));
  endproperty
  a_ep0_gate: assert property (p_ep0_gate) else $error("ep0 passed without local enable");

  property p_dma;
    (dma_evt.in_reload[2] && in_dma_enable_reg[2]) ##1 (!wr_fire && !rd_src) |=> usb_irq;
  endproperty
  a_dma: assert property (p_dma) else $error("dma reload not raised");

  c_read_served: cover property (rd_src && interrupt_source_code_reg != 6'h00);
  c_overwrite:   cover property (bus_evt.setup && setup_pend_reg);
  c_pre_frame:   cover property (pf_hit);
  c_dma_irq:     cover property ((|dma_evt.out_run) ##2 usb_irq);

endmodule : usb_interrupt_arbiter

/* File: tb/cpu_irq_model.sv */
// processor interrupt input model that counts request assertions
`timescale 1ns/1ps
module cpu_irq_model (
  // clock and reset
  input  wire logic   aclk,
  input  wire logic   aresetn,
  // request line from the arbiter
  input  wire logic   usb_irq,
  // rising edges seen so far
  output int unsigned raise_cnt
);
  logic irq_q;

  // level pin sampled like a core input, one count for each rise
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_q     <= 1'b0;
      raise_cnt <= 0;
    end else begin
      irq_q <= usb_irq;
      if (usb_irq && !irq_q) begin
        raise_cnt <= raise_cnt + 1;
      end
    end
  end
endmodule : cpu_irq_model

/* File: tb/usb_interrupt_arbiter_bench.sv */
// self-checking bench of the usb interrupt arbiter
`timescale 1ns/1ps
module usb_interrupt_arbiter_bench;
  logic              aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic              setup_buf_read, periph_idle, usb_irq, module_idle;
  logic              awready, wready, bvalid, arready, rvalid;
  logic [7:0]        awaddr, araddr, out_nak, in_nak;
  logic [31:0]       wdata, rdata, got;
  logic [1:0]        bresp, rresp, last_resp;
  irq_pkg::bus_evt_s bus_evt;
  irq_pkg::ep_evt_s  ep_evt;
  irq_pkg::dma_evt_s dma_evt;
  int unsigned       raise_cnt, a, b, cyc;
  int                error_cnt, samples_checked;
  logic [7:0]        en_addr [7] = '{8'h04, 8'h0c, 8'h14, 8'h18, 8'h1c, 8'h28, 8'h34};
  logic [31:0]       en_val  [7] = '{32'h7f, 32'hff, 32'hff, 32'h1, 32'h1, 32'hfe, 32'hfe};

  usb_interrupt_arbiter u_usb_interrupt_arbiter (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(4'hf), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arprot(3'h0),
    .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
    .rready(rready), .bus_evt(bus_evt), .setup_buf_read(setup_buf_read), .ep_evt(ep_evt),
    .dma_evt(dma_evt), .out_ep_nak_set(out_nak), .in_ep_nak_set(in_nak), .usb_irq(usb_irq),
    .periph_domain_idle_bit(periph_idle), .module_idle(module_idle));

  cpu_irq_model u_cpu_irq_model (
    .aclk(aclk), .aresetn(aresetn), .usb_irq(usb_irq), .raise_cnt(raise_cnt));

  // free-running 125 mhz clock
  initial begin
    aclk = 1'b0;
    forever #4 aclk = ~aclk;
  end

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  task automatic check(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : check

  // bounded wait, a hang here counts as a mismatch
  task automatic wait_hi(ref logic s);
    int n;
    n = 0;
    do begin
      @(posedge aclk);
      n++;
    end while (s !== 1'b1 && n < 200);
    if (s !== 1'b1) begin
      error_cnt++;
      $display("mismatch t=%0t handshake got=%h exp=%h", $time, s, 1'b1);
    end
  endtask : wait_hi

  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    @(posedge aclk);
    awaddr  <= ad;
    wdata   <= d;
    awvalid <= 1'b1;
    wvalid  <= 1'b1;
    bready  <= 1'b1;
    wait_hi(awready);
    awvalid <= 1'b0;
    wvalid  <= 1'b0;
    wait_hi(bvalid);
    last_resp = bresp;
    bready <= 1'b0;
  endtask : wr

  task automatic rd(input logic [7:0] ad);
    @(posedge aclk);
    araddr  <= ad;
    arvalid <= 1'b1;
    rready  <= 1'b1;
    wait_hi(arready);
    arvalid <= 1'b0;
    wait_hi(rvalid);
    got       = rdata;
    last_resp = rresp;
    rready <= 1'b0;
  endtask : rd

  // one-cycle pulse of the source vector, index order as in the code table
  task automatic ev(input logic [50:0] v);
    @(posedge aclk);
    bus_evt <= {v[5], v[3], v[2:0]};
    ep_evt  <= v[22:7];
    dma_evt <= v[50:23];
    @(posedge aclk);
    bus_evt <= '0;
    ep_evt  <= '0;
    dma_evt <= '0;
    #1;
    check(32'(out_nak), 32'(v[14:7]));
    check(32'(in_nak), 32'(v[22:15]));
    repeat (2) @(posedge aclk);
  endtask : ev

  function automatic int unsigned pick();
    int unsigned k;
    do k = $urandom_range(50, 0);
    while (k == 3 || k == 4 || k == 6); // write-one flags and timer left out
    return k;
  endfunction : pick

  initial begin
    {awvalid, wvalid, bready, arvalid, rready, setup_buf_read, periph_idle} = '0;
    {awaddr, araddr, wdata} = '0;
    {bus_evt, ep_evt, dma_evt} = '0;
    error_cnt = 0;
    samples_checked = 0;
    aresetn = 1'b0;
    repeat (12) @(posedge aclk);
    aresetn <= 1'b1;
    void'($urandom(38));
    rd(8'h38);
    check(got, 32'h0);
    rd(8'h44);
    check(32'(last_resp), 32'(irq_pkg::RESP_SLVERR));
    wr(8'h44, 32'h0);
    check(32'(last_resp), 32'(irq_pkg::RESP_SLVERR));
    for (int i = 0; i < 7; i++) wr(en_addr[i], en_val[i]);
    check(32'(last_resp), 32'(irq_pkg::RESP_OKAY));
    // random pairs, the extreme priorities first
    for (int i = 0; i < 24; i++) begin
      a = (i == 0) ? 0 : pick();
      do b = (i == 0) ? 50 : pick();
      while (b == a);
      ev((51'h1 << a) | (51'h1 << b));
      check(32'(usb_irq), 32'h1);
      rd(8'h38);
      check(got, ((a < b) ? a : b) + 1);
      rd(8'h38);
      check(got, ((a < b) ? b : a) + 1);
      rd(8'h38);
      check(got, 32'h0);
      repeat (2) @(posedge aclk);
      check(32'(usb_irq), 32'h0);
    end
    // every pair raises the line once and drops it after the second read
    check(raise_cnt, 32'd24);
    // masked bus events still flag but raise nothing
    wr(8'h04, 32'h0);
    ev(51'h27);
    check(32'(usb_irq), 32'h0);
    rd(8'h00);
    check(got, 32'h27);
    wr(8'h04, 32'h7f);
    repeat (2) @(posedge aclk);
    check(32'(usb_irq), 32'h1);
    wr(8'h00, 32'h27);
    repeat (2) @(posedge aclk);
    check(32'(usb_irq), 32'h0);
    // endpoint zero needs its local enable as well
    wr(8'h18, 32'h0);
    ev(51'h80);
    check(32'(usb_irq), 32'h0);
    wr(8'h18, 32'h1);
    rd(8'h38);
    check(got, 32'h8);
    // setup flags survive the code read
    ev(51'h8);
    rd(8'h38);
    rd(8'h38);
    check(got, 32'h4);
    ev(51'h8);
    rd(8'h00);
    check(got & 32'h18, 32'h18);
    wr(8'h00, 32'h18);
    rd(8'h38);
    check(got, 32'h0);
    setup_buf_read <= 1'b1;
    @(posedge aclk);
    setup_buf_read <= 1'b0;
    // pre-frame at the longest lead; the wait is long, so it runs once
    wr(8'h3c, 32'hff);
    ev(51'h20);
    rd(8'h38);
    check(got, 32'h6);
    cyc = 0;
    do begin
      @(posedge aclk);
      cyc++;
    end while (usb_irq !== 1'b1 && cyc < 90000);
    check(cyc + 4, irq_pkg::TICK_CYCLES * (irq_pkg::FRAME_TICKS - 255));
    rd(8'h38);
    check(got, 32'h7);
    // idle follows the peripheral domain only with permit set
    periph_idle <= 1'b1;
    repeat (6) @(posedge aclk);
    check(32'(module_idle), 32'h0);
    wr(8'h40, 32'h1);
    repeat (6) @(posedge aclk);
    check(32'(module_idle), 32'h1);
    rd(8'h40);
    check(got, 32'h3);
    periph_idle <= 1'b0;
    repeat (6) @(posedge aclk);
    check(32'(module_idle), 32'h0);
    check(32'(raise_cnt > 0), 32'h1);
    give_verdict();
  end

  // watchdog past the roughly 82k cycles the pre-frame wait dominates
  initial begin
    #760000;
    error_cnt++;
    give_verdict();
  end
endmodule : usb_interrupt_arbiter_bench
